// [shared/icu_pkg.sv]
// shared constants for the input capture unit
package icu_pkg;
  // register byte offsets
  localparam logic [7:0] ICU_OFF_CTRL    = 8'h00;
  localparam logic [7:0] ICU_OFF_CAPTURE = 8'h04;
  localparam logic [7:0] ICU_OFF_FLAG    = 8'h08;
  localparam logic [7:0] ICU_OFF_ENABLE  = 8'h0c;
  localparam logic [7:0] ICU_OFF_TSEL_A  = 8'h10;
  localparam logic [7:0] ICU_OFF_TSEL_B  = 8'h14;
  localparam logic [7:0] ICU_OFF_ROUTE   = 8'h18;
  // mode field codes
  localparam logic [3:0] ICU_MODE_OFF    = 4'h0;
  localparam logic [3:0] ICU_MODE_FALL   = 4'h4;
  localparam logic [3:0] ICU_MODE_RISE   = 4'h5;
  localparam logic [3:0] ICU_MODE_RISE4  = 4'h6;
  localparam logic [3:0] ICU_MODE_RISE16 = 4'h7;
  // time base selection codes
  localparam logic [1:0] ICU_TSEL_T1     = 2'h0;
  localparam logic [1:0] ICU_TSEL_T3     = 2'h1;
  localparam logic [1:0] ICU_TSEL_T5     = 2'h2;
  localparam logic [7:0] ICU_TSEL_A_RST  = 8'h00;
  localparam logic [7:0] ICU_TSEL_B_RST  = 8'h00;
  // field positions
  localparam int ICU_TSEL_A_POS = 0;
  localparam int ICU_TSEL_B_POS = 0;
  localparam logic [7:0] ICU_TSEL_A_MASK = 8'hdb;
  localparam logic [7:0] ICU_TSEL_B_MASK = 8'h0f;
  localparam logic [3:0] ICU_PRESC_RST   = 4'h0;
  localparam logic [3:0] ICU_PRESC_4     = 4'h3;
  localparam logic [3:0] ICU_PRESC_16    = 4'hf;
  localparam logic [1:0] ICU_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ICU_HSIZE_WORD    = 3'h2;
endpackage

// [design/icu_input_capture.sv]
// input capture unit with ahb-lite register slave
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module icu_input_capture
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // time bases
  input  wire logic [15:0] time_base_1,
  input  wire logic [15:0] time_base_3,
  input  wire logic [15:0] time_base_5,
  input  wire logic [2:0]  time_base_external,
  input  wire logic        sleep_mode,
  // capture pins, two routing choices
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_b,
  input  wire logic        pin_direction_bit,
  input  wire logic        port_data_out,
  // status
  output logic             capture_request_flag,
  output logic             capture_request_enable,
  output logic             capture_irq
);
  import icu_pkg::*;

  // checkers run on the core clock and sleep through reset
  default clocking icu_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic [3:0]  module_mode_field;
  logic [7:0]  capture_timer_select_a;
  logic [7:0]  capture_timer_select_b;
  logic        pin_route_select;
  logic [7:0]  capture_value_high;
  logic [7:0]  capture_value_low;
  logic [3:0]  presc;
  logic [1:0]  pin_meta;
  logic [1:0]  pin_safe;
  logic        pin_prev;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;
  logic        next_event;
  logic        next_capture;
  logic        pin_s;
  logic [1:0]  base_ix;
  logic [15:0] sel_count;
  logic        tb_runs;
  logic [1:0]  tsel;
  logic        flag_wr;

  // a mode code counts as capture only in the four event codes
  function automatic logic icu_is_capture(input logic [3:0] m);
    icu_is_capture = (m == ICU_MODE_FALL) || (m == ICU_MODE_RISE) ||
                     (m == ICU_MODE_RISE4) || (m == ICU_MODE_RISE16);
  endfunction

  // pick the count of one time base by its selection code
  function automatic logic [15:0] icu_pick(input logic [1:0] s,
                                           input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic [15:0] c);
    unique case (s)
      ICU_TSEL_T3: icu_pick = b;
      ICU_TSEL_T5: icu_pick = c;
      default:     icu_pick = a;
    endcase
  endfunction

  // code 3 has no timer of its own; it falls back to the first one
  function automatic logic [1:0] icu_base_ix(input logic [1:0] s);
    icu_base_ix = (s > ICU_TSEL_T5) ? ICU_TSEL_T1 : s;
  endfunction

  // both pins are synchronised before the route mux looks at them
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 2'h0;
      pin_safe <= 2'h0;
    end
    else
    begin
      pin_meta <= {capture_pin_b, capture_pin_a};
      pin_safe <= pin_meta;
    end
  end

  // port drive is already on this clock, so it skips the synchroniser
  always_comb
  begin
    pin_s = pin_route_select ? pin_safe[1] : pin_safe[0];
    if (!pin_direction_bit)
      pin_s = port_data_out;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_s;
  end

  // field of the first timer select register holds this unit's code
  assign tsel = capture_timer_select_a[ICU_TSEL_A_POS +: 2];
  assign sel_count = icu_pick(tsel, time_base_1, time_base_3, time_base_5);
  // internal time bases freeze during sleep, so no capture then
  assign base_ix = icu_base_ix(tsel);
  assign tb_runs = !sleep_mode || time_base_external[base_ix];

  always_comb
  begin
    next_event = 1'b0;
    unique case (module_mode_field)
      ICU_MODE_FALL:   next_event = pin_prev && !pin_s;
      ICU_MODE_RISE,
      ICU_MODE_RISE4,
      ICU_MODE_RISE16: next_event = !pin_prev && pin_s;
      default:         next_event = 1'b0;
    endcase
    next_event = next_event && tb_runs;
    next_capture = 1'b0;
    if (next_event)
    begin
      unique case (module_mode_field)
        ICU_MODE_RISE4:  next_capture = (presc[1:0] == ICU_PRESC_4[1:0]);
        ICU_MODE_RISE16: next_capture = (presc == ICU_PRESC_16);
        default:         next_capture = 1'b1;
      endcase
    end
  end

  // prescaler survives a change between capture modes on purpose
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      presc <= ICU_PRESC_RST;
    else if (!icu_is_capture(module_mode_field))
      presc <= ICU_PRESC_RST;
    else if (next_event)
      presc <= presc + 4'h1;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      capture_value_high <= 8'h00;
      capture_value_low  <= 8'h00;
    end
    else if (next_capture)
    begin
      capture_value_high <= sel_count[15:8];
      capture_value_low  <= sel_count[7:0];
    end
  end

  // ahb-lite address phase capture
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q  <= haddr[7:0];
    end
  end

  assign flag_wr = wr_pend && (addr_q == ICU_OFF_FLAG) && !hwdata[0];

  // flag: set beats a same-cycle software clear
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      capture_request_flag <= 1'b0;
    else if (next_capture)
      capture_request_flag <= 1'b1;
    else if (flag_wr)
      capture_request_flag <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      module_mode_field      <= ICU_MODE_OFF;
      capture_request_enable <= 1'b0;
      capture_timer_select_a <= ICU_TSEL_A_RST;
      capture_timer_select_b <= ICU_TSEL_B_RST;
      pin_route_select       <= 1'b0;
    end
    else if (wr_pend)
    begin
      unique case (addr_q)
        ICU_OFF_CTRL:   module_mode_field <= hwdata[3:0];
        ICU_OFF_ENABLE: capture_request_enable <= hwdata[0];
        ICU_OFF_TSEL_A:
          capture_timer_select_a <= hwdata[7:0] & ICU_TSEL_A_MASK;
        ICU_OFF_TSEL_B:
          capture_timer_select_b <= hwdata[7:0] & ICU_TSEL_B_MASK;
        ICU_OFF_ROUTE:  pin_route_select <= hwdata[0];
        default:        ;
      endcase
    end
  end

  always_comb
  begin
    hrdata = 32'h0;
    if (rd_pend)
    begin
      unique case (addr_q)
        ICU_OFF_CTRL:    hrdata = {28'h0, module_mode_field};
        ICU_OFF_CAPTURE:
          hrdata = {16'h0, capture_value_high, capture_value_low};
        ICU_OFF_FLAG:    hrdata = {31'h0, capture_request_flag};
        ICU_OFF_ENABLE:  hrdata = {31'h0, capture_request_enable};
        ICU_OFF_TSEL_A:  hrdata = {24'h0, capture_timer_select_a};
        ICU_OFF_TSEL_B:  hrdata = {24'h0, capture_timer_select_b};
        ICU_OFF_ROUTE:   hrdata = {31'h0, pin_route_select};
        default:         hrdata = 32'h0;
      endcase
    end
  end

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign capture_irq = capture_request_flag && capture_request_enable;

  a_flag_on_capture: assert property (
    next_capture
    |=> capture_request_flag)
    else $error("flag not set after capture");

  a_flag_sticky: assert property (
    capture_request_flag && !flag_wr
    |=> capture_request_flag)
    else $error("flag dropped without a clear");

  a_flag_clear: assert property (
    flag_wr && !next_capture
    |=> !capture_request_flag)
    else $error("flag not cleared by software write");

  a_value_loaded: assert property (
    next_capture
    |=> {capture_value_high, capture_value_low} == $past(sel_count))
    else $error("capture pair does not hold the count");

  a_value_held: assert property (
    !next_capture
    |=> $stable({capture_value_high, capture_value_low}))
    else $error("capture pair changed without an event");

  a_value_read: assert property (
    rd_pend && addr_q == ICU_OFF_CAPTURE
    |-> hrdata == {16'h0, capture_value_high, capture_value_low})
    else $error("capture pair not read as one word");

  a_presc_clear: assert property (
    !icu_is_capture(module_mode_field)
    |=> presc == ICU_PRESC_RST)
    else $error("prescaler not cleared outside capture");

  a_presc_keep: assert property (
    icu_is_capture(module_mode_field) && !next_event
    |=> $stable(presc))
    else $error("prescaler moved without an event");

  a_mode_quiet: assert property (
    !icu_is_capture(module_mode_field)
    |-> !next_capture)
    else $error("capture outside a capture mode");

  a_rise4_gap: assert property (
    module_mode_field == ICU_MODE_RISE4 && next_event
      && presc[1:0] != ICU_PRESC_4[1:0] |-> !next_capture)
    else $error("capture before fourth edge");

  a_rise16_gap: assert property (
    module_mode_field == ICU_MODE_RISE16 && next_event
      && presc != ICU_PRESC_16 |-> !next_capture)
    else $error("capture before sixteenth edge");

  a_rise_edge: assert property (
    module_mode_field == ICU_MODE_RISE && next_capture
    |-> !$past(pin_s) && pin_s)
    else $error("rising capture without rising edge");

  a_fall_edge: assert property (
    module_mode_field == ICU_MODE_FALL && next_capture
    |-> $past(pin_s) && !pin_s)
    else $error("falling capture without falling edge");

  a_mode_write: assert property (
    wr_pend && addr_q == ICU_OFF_CTRL
    |=> module_mode_field == $past(hwdata[3:0]))
    else $error("mode field write lost");

  a_tsel_write: assert property (
    wr_pend && addr_q == ICU_OFF_TSEL_A
    |=> capture_timer_select_a == ($past(hwdata[7:0]) & ICU_TSEL_A_MASK))
    else $error("time base select write lost");

  a_sleep_stall: assert property (
    sleep_mode && !time_base_external[icu_base_ix(tsel)]
    |-> !next_capture)
    else $error("capture during sleep on internal clock");
endmodule

// [bench/icu_pin_model.sv]
// external event source driving the two capture pins
`timescale 1ns/1ps
module icu_pin_model
(
  // clock
  input  wire logic core_clk,
  // pins
  output logic      pin_a,
  output logic      pin_b
);
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // level held 6 cycles: sync needs 2, capture lands within 4
  task automatic drive(input logic sel, input logic lvl);
    @(posedge core_clk);
    if (sel)
      pin_b <= lvl;
    else
      pin_a <= lvl;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the input capture unit
`timescale 1ns/1ps
module testbench;
  import icu_pkg::*;
  logic        core_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        sleep_mode = 1'b0, pin_direction_bit = 1'b1;
  logic        port_data_out = 1'b0, hreadyout, capture_request_flag;
  logic        capture_irq, capture_pin_a, capture_pin_b, hresp;
  logic        capture_request_enable;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0, time_base_external = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] time_base_1 = 16'h0, time_base_3 = 16'h0;
  logic [15:0] time_base_5 = 16'h0, m_cap;
  logic [3:0]  m_mode;
  logic [1:0]  tsel;
  logic        m_flag, m_en, route;
  int          m_presc, err_total, compares, seed;

  icu_input_capture i_dut
  (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .time_base_1(time_base_1), .time_base_3(time_base_3),
    .time_base_5(time_base_5), .time_base_external(time_base_external),
    .sleep_mode(sleep_mode), .capture_pin_a(capture_pin_a),
    .capture_pin_b(capture_pin_b), .pin_direction_bit(pin_direction_bit),
    .port_data_out(port_data_out),
    .capture_request_flag(capture_request_flag),
    .capture_request_enable(capture_request_enable),
    .capture_irq(capture_irq)
  );
  icu_pin_model i_pin
  (
    .core_clk(core_clk), .pin_a(capture_pin_a), .pin_b(capture_pin_b)
  );

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= ICU_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= ICU_HSIZE_WORD;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic cmp;
    rdchk("capture", ICU_OFF_CAPTURE, {16'h0, m_cap});
    chk("flag", {31'h0, m_flag}, {31'h0, capture_request_flag});
    chk("irq", {31'h0, m_flag & m_en}, {31'h0, capture_irq});
    chk("enable", {31'h0, m_en}, {31'h0, capture_request_enable});
  endtask
  task automatic set_mode(input logic [3:0] m);
    bus(1'b1, ICU_OFF_CTRL, {28'h0, m});
    m_mode = m;
    if (m < ICU_MODE_FALL || m > ICU_MODE_RISE16)
      m_presc = 0;
  endtask
  task automatic rst(input int n);
    reset <= 1'b1;
    repeat (n) @(posedge core_clk);
    reset <= 1'b0;
    {m_flag, m_en, route, tsel, m_mode, m_cap} = '0;
    m_presc = 0;
  endtask
  // one pin level change, then the model's view is compared
  task automatic ev(input logic lvl);
    logic pv, hit;
    logic [1:0] ix;
    logic [15:0] tv;
    pv = !pin_direction_bit ? port_data_out : route ? capture_pin_b
                                                   : capture_pin_a;
    time_base_1 <= 16'($random(seed));
    time_base_3 <= 16'($random(seed));
    time_base_5 <= 16'($random(seed));
    if (pin_direction_bit)
      i_pin.drive(route, lvl);
    else
    begin
      @(posedge core_clk);
      port_data_out <= lvl;
      repeat (6) @(posedge core_clk);
    end
    tv = tsel == 2'h1 ? time_base_3 : tsel == 2'h2 ? time_base_5 : time_base_1;
    ix = tsel == 2'h3 ? 2'h0 : tsel;
    hit = 1'b0;
    if (pv !== lvl && m_mode >= ICU_MODE_FALL && m_mode <= ICU_MODE_RISE16
        && !(sleep_mode && !time_base_external[ix]))
    begin
      if (m_mode == ICU_MODE_FALL)
        hit = !lvl;
      else if (m_mode == ICU_MODE_RISE)
        hit = lvl;
      else if (lvl)
      begin
        m_presc++;
        hit = m_presc % (m_mode == ICU_MODE_RISE4 ? 4 : 16) == 0;
      end
    end
    if (hit)
    begin
      m_flag = 1'b1;
      m_cap = tv;
    end
    cmp();
  endtask
  task automatic pulse;
    ev(1'b1);
    ev(1'b0);
  endtask

  initial
  begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    seed = 32'he0e2;
    err_total = 0;
    compares = 0;
    rst(10);
    for (int i = 0; i < 8; i++)
      rdchk("reset value", 8'(i * 4), 32'h0);
    bus(1'b1, ICU_OFF_TSEL_A, 32'hff);
    rdchk("tsel_a", ICU_OFF_TSEL_A, {24'h0, ICU_TSEL_A_MASK});
    bus(1'b1, ICU_OFF_TSEL_B, 32'hff);
    rdchk("tsel_b", ICU_OFF_TSEL_B, {24'h0, ICU_TSEL_B_MASK});
    bus(1'b1, 8'h1c, 32'hff);
    rdchk("unmapped", 8'h1c, 32'h0);
    bus(1'b1, ICU_OFF_ENABLE, 32'h1);
    m_en = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, ICU_OFF_TSEL_A, 32'(s));
      tsel = 2'(s);
      set_mode(ICU_MODE_FALL);
      pulse();
      set_mode(ICU_MODE_RISE);
      pulse();
    end
    bus(1'b1, ICU_OFF_FLAG, 32'h1);
    cmp();
    bus(1'b1, ICU_OFF_FLAG, 32'h0);
    m_flag = 1'b0;
    cmp();
    set_mode(ICU_MODE_OFF);
    set_mode(ICU_MODE_RISE4);
    repeat (9) pulse();
    set_mode(ICU_MODE_RISE16);
    repeat (10) pulse();
    set_mode(ICU_MODE_OFF);
    set_mode(ICU_MODE_RISE16);
    repeat (17) pulse();
    bus(1'b1, ICU_OFF_ENABLE, 32'h0);
    m_en = 1'b0;
    set_mode(4'h8);
    bus(1'b1, ICU_OFF_FLAG, 32'h0);
    m_flag = 1'b0;
    cmp();
    bus(1'b1, ICU_OFF_ENABLE, 32'h1);
    m_en = 1'b1;
    repeat (2) pulse();
    set_mode(ICU_MODE_RISE4);
    repeat (7) pulse();
    rst(2);
    set_mode(ICU_MODE_RISE4);
    repeat (5) pulse();
    bus(1'b1, ICU_OFF_ROUTE, 32'h1);
    route = 1'b1;
    set_mode(ICU_MODE_RISE);
    i_pin.drive(1'b0, 1'b1);
    cmp();
    pulse();
    i_pin.drive(1'b0, 1'b0);
    bus(1'b1, ICU_OFF_ROUTE, 32'h0);
    route = 1'b0;
    sleep_mode <= 1'b1;
    @(posedge core_clk);
    pulse();
    time_base_external <= 3'h1;
    @(posedge core_clk);
    pulse();
    sleep_mode <= 1'b0;
    pin_direction_bit <= 1'b0;
    @(posedge core_clk);
    pulse();
    finish_test();
  end
endmodule
